// >>> logic/mcs_map.svh
// constants of the monitoring case cut-off logic
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define MCS_NTAB        2
`define MCS_NCASE       8
`define MCS_NPATH       4
`define MCS_NIN         4
`define MCS_CASE_W      3
`define MCS_SPD_W       16
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MCS_A_CTRL      8'h00
`define MCS_A_STATUS    8'h04
`define MCS_A_ACTIVE    8'h08
`define MCS_A_PATHS     8'h0C
`define MCS_A_INPUTS    8'h10
`define MCS_A_SPEED     8'h14
`define MCS_A_TOL       8'h18
`define MCS_A_PMAP      8'h1C
`define MCS_A_CASE0     8'h40
`define MCS_A_SPDLO0    8'h80
`define MCS_A_SPDHI0    8'hC0
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define MCS_C_RUN       0
`define MCS_C_ANTI      1
`define MCS_C_SPDMODE   3:2
`define MCS_C_RESTART   4
`define MCS_C_RSTOVR    11:8
`define MCS_C_SEQEN     12
// ----------------------------------------------------------------
// case word fields: enable, sleep, input pattern, behaviours, successors
// ----------------------------------------------------------------
`define MCS_K_EN        0
`define MCS_K_SLEEP     1
`define MCS_K_PAT       5:2
`define MCS_K_CARE      9:6
`define MCS_K_BEH       17:10
`define MCS_K_S0        20:18
`define MCS_K_S0V       21
`define MCS_K_S1        24:22
`define MCS_K_S1V       25
`define MCS_K_FIELD     29:26
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MCS_CLK_HZ      25000000
`define MCS_MISM_S      60
`endif

// >>> logic/mcs_pkg.sv
// types of the monitoring case cut-off logic
package mcs_pkg;
  typedef enum logic [1:0] {MCS_WAIT, MCS_RUN, MCS_ERR} mcs_state_t;
  typedef enum logic [1:0] {MCS_B_FIELD, MCS_B_OFF, MCS_B_ONNS, MCS_B_ONS} mcs_beh_t;
  typedef enum logic [1:0] {MCS_SP_NONE, MCS_SP_RANGE, MCS_SP_LIMIT} mcs_spd_t;
  typedef struct packed {
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] haddr;
  } mcs_ahb_req_t;
endpackage

// >>> logic/mcs_cutoff.sv
// monitoring case selection and cut-off path logic with ahb-lite registers
`timescale 1ns/100ps
`include "mcs_map.svh"
// ----------------------------------------------------------------
// Functional notes
// - each path belongs to one table only
// - no case after start: outputs off, waiting
// - case lost while running: outputs off, error
// - sleep case present: enter sleep
// - case active only for its exact inputs
// - range mode: speed inside range selects case
// - limit mode: speed out of range, safety off
// - limit mode: encoder mismatch ignored for 60 seconds
// - one cut-off path per field
// - global restart interlock, per-output override
// - forced-off path held off
// - non-safe forced-on: safety off, non-safety on
// - safe forced-on path stays on
// - unassigned path defaults to forced-off
// - illegal successor case: safety outputs off
// - antivalent channels not inverted: off, error
// ----------------------------------------------------------------
module mcs_cutoff
  import mcs_pkg::*;
#(
  parameter int unsigned MISM_CYC = `MCS_MISM_S * `MCS_CLK_HZ
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // ahb-lite slave
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  // static control inputs, two channels each
  input  wire logic [`MCS_NIN-1:0]     ctl_a,
  input  wire logic [`MCS_NIN-1:0]     ctl_b,
  // speed from two encoders
  input  wire logic [`MCS_SPD_W-1:0]   speed_a,
  input  wire logic [`MCS_SPD_W-1:0]   speed_b,
  // field evaluation, one bit per field, high when an object is seen
  input  wire logic [`MCS_NPATH-1:0]   field_hit,
  // restart command
  input  wire logic                    restart_req,
  // outputs
  output logic      [`MCS_NPATH-1:0]   safe_out,
  output logic      [`MCS_NPATH-1:0]   nonsafe_out,
  output logic                         sleep_mode,
  output logic                         wait_inputs,
  output logic                         error_flag
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0]            ctrl;                              // control word
  logic [31:0]            tol;                               // speed tolerance
  logic [`MCS_NPATH-1:0]  pmap;                              // path to table map
  logic [31:0]            case_cfg [`MCS_NTAB*`MCS_NCASE];   // case words
  logic [`MCS_SPD_W-1:0]  spd_lo   [`MCS_NTAB*`MCS_NCASE];   // range low
  logic [`MCS_SPD_W-1:0]  spd_hi   [`MCS_NTAB*`MCS_NCASE];   // range high
  mcs_state_t             state;                             // run state
  logic [`MCS_CASE_W-1:0] act      [`MCS_NTAB];              // active case
  logic [`MCS_NTAB-1:0]   act_ok;                            // table has case
  logic [`MCS_NPATH-1:0]  latch_off;                         // restart interlock
  logic [31:0]            mism_cnt;                          // mismatch timer
  logic                   seq_bad;                           // sequence fault
  mcs_ahb_req_t           ap;                                // latched address phase
  logic                   ap_v;                              // data phase pending

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // index of a case word
  function automatic int cidx(input int t, input int c);
    return t * `MCS_NCASE + c;
  endfunction

  // absolute difference of two speeds
  function automatic logic [`MCS_SPD_W-1:0] sdiff(input logic [`MCS_SPD_W-1:0] a,
                                                  input logic [`MCS_SPD_W-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // ----------------------------------------------------------------
  // case selection
  // ----------------------------------------------------------------
  logic [`MCS_SPD_W-1:0]  speed;                             // lower of both
  logic                   anti_bad;                          // channel fault
  logic [`MCS_CASE_W-1:0] sel      [`MCS_NTAB];              // selected case
  logic [`MCS_NTAB-1:0]   sel_ok;                            // exactly one hit
  logic [`MCS_NTAB-1:0]   sel_sleep;                         // sleep case hit
  logic [`MCS_NTAB-1:0]   spd_out;                           // limit violation
  logic                   mism_hold;                         // mismatch too long
  mcs_spd_t               smode;                             // speed mode
  logic [`MCS_NPATH-1:0]  rst_ovr;                           // per-path interlock flip

  assign rst_ovr   = ctrl[`MCS_C_RSTOVR];

  assign smode     = mcs_spd_t'(ctrl[`MCS_C_SPDMODE]);
  assign speed     = (speed_a < speed_b) ? speed_a : speed_b;
  assign anti_bad  = ctrl[`MCS_C_ANTI] && ((ctl_a ^ ctl_b) != {`MCS_NIN{1'b1}});
  assign mism_hold = (mism_cnt >= MISM_CYC);

  // per table, find the unique case whose conditions match
  always_comb begin
    int    k;
    int    hits;
    logic  m;
    logic  inr;
    k    = 0;
    hits = 0;
    m    = 1'b0;
    inr  = 1'b0;
    for (int t = 0; t < `MCS_NTAB; t++) begin
      sel[t]       = '0;
      sel_sleep[t] = 1'b0;
      spd_out[t]   = 1'b0;
      hits         = 0;
      for (int c = 0; c < `MCS_NCASE; c++) begin
        k   = cidx(t, c);
        inr = (speed >= spd_lo[k]) && (speed <= spd_hi[k]);
        // exact masked input pattern
        m   = case_cfg[k][`MCS_K_EN] &&
              (((ctl_a ^ case_cfg[k][`MCS_K_PAT]) & case_cfg[k][`MCS_K_CARE]) == '0);
        if (smode == MCS_SP_RANGE)
          m = m && inr;
        if (m) begin
          hits   = hits + 1;
          sel[t] = c[`MCS_CASE_W-1:0];
          if (case_cfg[k][`MCS_K_SLEEP])
            sel_sleep[t] = 1'b1;
          if (smode == MCS_SP_LIMIT && !inr)
            spd_out[t] = 1'b1;
        end
      end
      sel_ok[t] = (hits == 1) && !anti_bad;
    end
  end

  // ----------------------------------------------------------------
  // encoder mismatch timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn)
      mism_cnt <= '0;
    else if (smode != MCS_SP_LIMIT || sdiff(speed_a, speed_b) <= tol[`MCS_SPD_W-1:0])
      mism_cnt <= '0;
    else if (!mism_hold)
      mism_cnt <= mism_cnt + 32'h00000001;
  end

  // ----------------------------------------------------------------
  // run state: waiting, running, error
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn)
      state <= MCS_WAIT;
    else if (!ctrl[`MCS_C_RUN])
      state <= MCS_WAIT;
    else begin
      unique case (state)
        MCS_WAIT: if (&sel_ok) state <= MCS_RUN;
        MCS_RUN:  if (!(&sel_ok)) state <= MCS_ERR;
        MCS_ERR:  if (restart_req && (&sel_ok)) state <= MCS_RUN;
      endcase
    end
  end

  // active case per table and successor check
  always_ff @(posedge clk) begin
    if (!resetn) begin
      act_ok  <= '0;
      seq_bad <= 1'b0;
      for (int t = 0; t < `MCS_NTAB; t++)
        act[t] <= '0;
    end else begin
      act_ok <= sel_ok;
      // restart clears first so a fault in the same cycle still sets
      if (restart_req)
        seq_bad <= 1'b0;
      for (int t = 0; t < `MCS_NTAB; t++) begin
        if (sel_ok[t] && act_ok[t] && sel[t] != act[t] && ctrl[`MCS_C_SEQEN]) begin
          // successor must be one of up to two listed, or unrestricted
          automatic logic [31:0] w = case_cfg[cidx(t, int'(act[t]))];
          if ((w[`MCS_K_S0V] || w[`MCS_K_S1V]) &&
              !(w[`MCS_K_S0V] && w[`MCS_K_S0] == sel[t]) &&
              !(w[`MCS_K_S1V] && w[`MCS_K_S1] == sel[t]))
            seq_bad <= 1'b1;
        end
        if (sel_ok[t])
          act[t] <= sel[t];
      end
    end
  end

  // ----------------------------------------------------------------
  // cut-off paths
  // ----------------------------------------------------------------
  logic [`MCS_NPATH-1:0] next_safe;                          // path safety level
  logic [`MCS_NPATH-1:0] next_ns;                            // path non-safety level

  always_comb begin
    int       t;
    mcs_beh_t b;
    logic     fld;
    t   = 0;
    b   = MCS_B_OFF;
    fld = 1'b0;
    for (int p = 0; p < `MCS_NPATH; p++) begin
      t   = int'(pmap[p]);
      b   = mcs_beh_t'(2'(case_cfg[cidx(t, int'(act[t]))][`MCS_K_BEH] >> (2 * p)));
      fld = 1'(case_cfg[cidx(t, int'(act[t]))][`MCS_K_FIELD] >> p);
      if (b == MCS_B_FIELD && !fld)
        b = MCS_B_OFF;
      unique case (b)
        MCS_B_FIELD: begin
          next_safe[p] = !field_hit[p];
          next_ns[p]   = !field_hit[p];
        end
        MCS_B_OFF: begin
          next_safe[p] = 1'b0;
          next_ns[p]   = 1'b0;
        end
        MCS_B_ONNS: begin
          next_safe[p] = 1'b0;
          next_ns[p]   = 1'b1;
        end
        MCS_B_ONS: begin
          next_safe[p] = 1'b1;
          next_ns[p]   = 1'b1;
        end
      endcase
    end
  end

  // restart interlock: a path whose safety level dropped keeps its safety output off until restart
  always_ff @(posedge clk) begin
    if (!resetn)
      latch_off <= '0;
    else
      for (int p = 0; p < `MCS_NPATH; p++) begin
        // a path still low keeps its latch even while restart is asked
        if ((ctrl[`MCS_C_RESTART] ^ rst_ovr[p]) && !next_safe[p])
          latch_off[p] <= 1'b1;
        else if (restart_req)
          latch_off[p] <= 1'b0;
      end
  end

  // output flops
  always_ff @(posedge clk) begin
    if (!resetn) begin
      safe_out    <= '0;
      nonsafe_out <= '0;
      sleep_mode  <= 1'b0;
      wait_inputs <= 1'b1;
      error_flag  <= 1'b0;
    end else begin
      wait_inputs <= (state == MCS_WAIT);
      error_flag  <= (state == MCS_ERR) || anti_bad;
      sleep_mode  <= (state == MCS_RUN) && (|sel_sleep);
      if (state != MCS_RUN || !(&sel_ok)) begin
        safe_out    <= '0;
        nonsafe_out <= '0;
      end else begin
        safe_out    <= (seq_bad || (|spd_out) || mism_hold) ? '0 :
                       next_safe & ~latch_off;
        nonsafe_out <= next_ns;
      end
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ap_v <= 1'b0;
      ap   <= '0;
    end else if (hready) begin
      ap_v <= hsel && htrans[1];
      ap   <= '{htrans: htrans, hwrite: hwrite, hsize: hsize, haddr: haddr};
    end
  end

  // register writes in the data phase
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl <= '0;
      tol  <= '0;
      pmap <= '0;
      for (int i = 0; i < `MCS_NTAB*`MCS_NCASE; i++) begin
        case_cfg[i] <= '0;
        spd_lo[i]   <= '0;
        spd_hi[i]   <= '0;
      end
    end else if (ap_v && ap.hwrite) begin
      unique case (ap.haddr[7:6])
        2'h1: case_cfg[ap.haddr[5:2]] <= hwdata;
        2'h2: spd_lo[ap.haddr[5:2]]   <= hwdata[`MCS_SPD_W-1:0];
        2'h3: spd_hi[ap.haddr[5:2]]   <= hwdata[`MCS_SPD_W-1:0];
        2'h0: begin
          if (ap.haddr[7:0] == `MCS_A_CTRL) ctrl <= hwdata;
          if (ap.haddr[7:0] == `MCS_A_TOL)  tol  <= hwdata;
          if (ap.haddr[7:0] == `MCS_A_PMAP) pmap <= hwdata[`MCS_NPATH-1:0];
        end
      endcase
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    hrdata = '0;
    if (ap_v && !ap.hwrite) begin
      unique case (ap.haddr[7:6])
        2'h1: hrdata = case_cfg[ap.haddr[5:2]];
        2'h2: hrdata = {16'h0000, spd_lo[ap.haddr[5:2]]};
        2'h3: hrdata = {16'h0000, spd_hi[ap.haddr[5:2]]};
        2'h0: begin
          unique case (ap.haddr[7:0])
            `MCS_A_CTRL:   hrdata = ctrl;
            `MCS_A_STATUS: hrdata = {27'h0000000, seq_bad, sleep_mode, error_flag,
                                     wait_inputs, state == MCS_RUN};
            `MCS_A_ACTIVE: hrdata = {22'h000000, act_ok, 1'b0, act[1], 1'b0, act[0]};
            `MCS_A_PATHS:  hrdata = {24'h000000, nonsafe_out, safe_out};
            `MCS_A_INPUTS: hrdata = {24'h000000, ctl_b, ctl_a};
            `MCS_A_SPEED:  hrdata = {speed_b, speed_a};
            `MCS_A_TOL:    hrdata = tol;
            `MCS_A_PMAP:   hrdata = {28'h0000000, pmap};
            default:       hrdata = '0;
          endcase
        end
      endcase
    end
  end

endmodule

// >>> verification/mcs_cutoff_sva.sv
// assertion checker of the monitoring case cut-off logic
`timescale 1ns/100ps
`include "mcs_map.svh"
module mcs_cutoff_chk
  import mcs_pkg::*;
#(
  parameter int unsigned MISM_CYC = 20
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  resetn,
  // bus
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  // control and outputs
  input wire logic [`MCS_NIN-1:0]   ctl_a,
  input wire logic [`MCS_NIN-1:0]   ctl_b,
  input wire logic                  restart_req,
  input wire logic [`MCS_NPATH-1:0] safe_out,
  input wire logic [`MCS_NPATH-1:0] nonsafe_out,
  input wire logic                  sleep_mode,
  input wire logic                  wait_inputs,
  input wire logic                  error_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // bus snooping
  // ----------------------------------------------------------------
  logic        dp_v;     // a data phase is running
  logic        dp_w;     // it is a write
  logic [7:0]  dp_a;     // its offset
  logic [31:0] ctrl_q;   // shadow of the control word
  logic        anti_bad; // channels not inverted while checked
  logic        rd_st;    // status read in data phase
  logic        rd_pa;    // path read in data phase
  // track address phases
  always_ff @(posedge clk) begin
    dp_v <= resetn && hsel && hready && htrans[1];
    dp_a <= haddr[7:0];
    dp_w <= hwrite;
  end
  // keep a copy of the control word
  always_ff @(posedge clk) begin
    if (!resetn) ctrl_q <= 32'h0;
    else if (dp_v && dp_w && hready && dp_a == `MCS_A_CTRL) ctrl_q <= hwdata;
  end
  assign anti_bad = ctrl_q[`MCS_C_RUN] && ctrl_q[`MCS_C_ANTI] && (ctl_a != ~ctl_b);
  assign rd_st = dp_v && !dp_w && dp_a == `MCS_A_STATUS;
  assign rd_pa = dp_v && !dp_w && dp_a == `MCS_A_PATHS;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_wait_off; wait_inputs |-> safe_out == '0 && nonsafe_out == '0; endproperty
  a_wait_off: assert property (p_wait_off)
    else $error("outputs on while waiting for inputs");
  property p_start; !$past(resetn) |-> wait_inputs && !error_flag; endproperty
  a_start: assert property (p_start)
    else $error("not waiting after reset");
  property p_err_off; error_flag |-> safe_out == '0 && nonsafe_out == '0; endproperty
  a_err_off: assert property (p_err_off)
    else $error("outputs on during error");
  property p_err_hold;
    error_flag && !restart_req && !$past(restart_req) |=> error_flag;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error cleared without restart");
  property p_anti; anti_bad [*2] |-> ##[0:3] (error_flag && safe_out == '0); endproperty
  a_anti: assert property (p_anti)
    else $error("channel mismatch not reacted to");
  property p_stat; rd_st |-> hrdata[3:1] == {sleep_mode, error_flag, wait_inputs}; endproperty
  a_stat: assert property (p_stat)
    else $error("status word differs from flags");
  property p_paths; rd_pa |-> hrdata[7:0] == {nonsafe_out, safe_out}; endproperty
  a_paths: assert property (p_paths)
    else $error("path word differs from outputs");
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay)
    else $error("bus answer not ready or not okay");
  // main scenarios reached
  c_err: cover property ($rose(error_flag));
  c_sleep: cover property ($rose(sleep_mode));
  c_run: cover property ($fell(wait_inputs));
endmodule
bind mcs_cutoff mcs_cutoff_chk #(.MISM_CYC(MISM_CYC)) mcs_cutoff_chk_inst (
  .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .ctl_a(ctl_a), .ctl_b(ctl_b),
  .restart_req(restart_req), .safe_out(safe_out), .nonsafe_out(nonsafe_out),
  .sleep_mode(sleep_mode), .wait_inputs(wait_inputs), .error_flag(error_flag)
);

// >>> verification/mcs_ctl_model.sv
// machine control model driving static inputs and encoder speeds
`timescale 1ns/100ps
`include "mcs_map.svh"
module mcs_ctl_model
  import mcs_pkg::*;
#(
  parameter int DLY = 2 // cycles the controller needs to switch
) (
  // clock
  input wire logic                  clk,
  // commands from the bench
  input wire logic [`MCS_NIN-1:0]   pat,
  input wire logic                  bad,
  input wire logic [`MCS_SPD_W-1:0] spd,
  input wire logic [`MCS_SPD_W-1:0] spd_b,
  // lines to the device
  output logic [`MCS_NIN-1:0]       ctl_a,
  output logic [`MCS_NIN-1:0]       ctl_b,
  output logic [`MCS_SPD_W-1:0]     speed_a,
  output logic [`MCS_SPD_W-1:0]     speed_b
);
  logic [`MCS_NIN-1:0] cur = '0; // pattern on the lines
  int                  cnt = 0;  // switching delay
  // whole pattern switches at once after the delay, never half-way
  always @(posedge clk) begin
    if (pat != cur && cnt < DLY) cnt <= cnt + 1;
    else begin
      cur <= pat;
      cnt <= 0;
    end
  end
  // second channel inverted unless a fault is commanded
  assign ctl_a = cur;
  assign ctl_b = bad ? cur : ~cur;
  assign speed_a = spd;
  assign speed_b = spd_b;
endmodule

// >>> verification/test_monitoring_case_cutoff_logic.sv
// self-checking testbench of the monitoring case cut-off logic
`timescale 1ns/100ps
`include "mcs_map.svh"
module test_monitoring_case_cutoff_logic
  import mcs_pkg::*;
;
  logic        clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        hready, hreadyout, hresp, restart_req = 1'b0, bad = 1'b0;
  logic        sleep_mode, wait_inputs, error_flag;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  ctl_a, ctl_b, safe_out, nonsafe_out, field_hit = 4'h0, pat = 4'h0;
  logic [15:0] speed_a, speed_b, spd = 16'h0032, spd_b = 16'h0032;
  int          n_fail = 0, total_checks = 0;
  // ----------------------------------------------------------------
  // clock, bus and parts
  // ----------------------------------------------------------------
  always #20 clk = ~clk;
  assign hready = hreadyout;
  mcs_cutoff #(.MISM_CYC(20)) mcs_cutoff_inst (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ctl_a(ctl_a),
    .ctl_b(ctl_b), .speed_a(speed_a), .speed_b(speed_b), .field_hit(field_hit),
    .restart_req(restart_req), .safe_out(safe_out), .nonsafe_out(nonsafe_out),
    .sleep_mode(sleep_mode), .wait_inputs(wait_inputs), .error_flag(error_flag));
  mcs_ctl_model #(.DLY(2)) mcs_ctl_model_inst (
    .clk(clk), .pat(pat), .bad(bad), .spd(spd), .spd_b(spd_b), .ctl_a(ctl_a),
    .ctl_b(ctl_b), .speed_a(speed_a), .speed_b(speed_b));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one edge with hready high, bounded
  task automatic edge_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) begin
      n_fail++;
      conclude();
    end
  endtask
  // single word transfer: address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    edge_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    r = hrdata;
  endtask
  // case word: enable, sleep, pattern, care, behaviours, fields, successor
  function automatic logic [31:0] cw(logic sl, logic [3:0] p, logic [3:0] c,
                                     logic [7:0] b, logic [3:0] f, logic [3:0] s);
    logic [31:0] w;
    w = 32'h0;
    w[`MCS_K_EN] = 1'b1;
    w[`MCS_K_SLEEP] = sl;
    w[`MCS_K_PAT] = p;
    w[`MCS_K_CARE] = c;
    w[`MCS_K_BEH] = b;
    w[`MCS_K_FIELD] = f;
    w[`MCS_K_S0] = s[2:0];
    w[`MCS_K_S0V] = s[3];
    return w;
  endfunction
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  task automatic kick();
    restart_req <= 1'b1;
    @(posedge clk);
    restart_req <= 1'b0;
    settle();
  endtask
  task automatic outs(input logic [3:0] s);
    chk("safe_out", {28'h0, safe_out}, {28'h0, s});
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(`MCS_A_STATUS, 1'b0, 32'h0); chk("status", r, 32'h2);
    bus(`MCS_A_CTRL, 1'b0, 32'h0); chk("ctrl", r, 32'h0);
    bus(8'h3C, 1'b0, 32'h0); chk("unmapped", r, 32'h0);
    // case0 field, unassigned, forced non-safe, forced safe; case1 all off
    bus(`MCS_A_CASE0, 1'b1, cw(0, 4'h1, 4'h3, 8'hE0, 4'h1, 4'h9));
    bus(`MCS_A_CASE0 + 8'h04, 1'b1, cw(0, 4'h2, 4'h3, 8'h55, 4'hF, 4'h0));
    bus(`MCS_A_CASE0 + 8'h08, 1'b1, cw(1, 4'h3, 4'h3, 8'hFF, 4'h0, 4'h0));
    bus(`MCS_A_CASE0 + 8'h20, 1'b1, cw(0, 4'h0, 4'h0, 8'hFF, 4'h0, 4'h0));
    bus(`MCS_A_SPDLO0, 1'b1, 32'd10);
    bus(`MCS_A_SPDHI0, 1'b1, 32'd100);
    bus(`MCS_A_SPDLO0 + 8'h20, 1'b1, 32'd10);
    bus(`MCS_A_SPDHI0 + 8'h20, 1'b1, 32'd100);
    bus(`MCS_A_TOL, 1'b1, 32'd5);
    bus(`MCS_A_CTRL, 1'b1, 32'h3);
    settle();
    chk("wait", {31'h0, wait_inputs}, 32'h1); outs(4'h0);
    pat <= 4'h1;
    settle();
    outs(4'h9);
    chk("nonsafe", {30'h0, nonsafe_out[2:1]}, 32'h2);
    bus(`MCS_A_ACTIVE, 1'b0, 32'h0); chk("active", r, 32'h300);
    bus(`MCS_A_PATHS, 1'b0, 32'h0); chk("paths", {28'h0, r[3:0]}, 32'h9);
    field_hit <= 4'h1;
    settle();
    outs(4'h8);
    bus(`MCS_A_PMAP, 1'b1, 32'h1);
    settle();
    outs(4'h9);
    bus(`MCS_A_PMAP, 1'b1, 32'h0);
    field_hit <= 4'h0;
    pat <= 4'h2;
    settle();
    outs(4'h0); chk("nonsafe", {28'h0, nonsafe_out}, 32'h0);
    pat <= 4'h1;
    settle();
    outs(4'h9);
    // sequence: case0 may only go on to case1, so the sleep case turns the safety outputs off
    bus(`MCS_A_CTRL, 1'b1, 32'h1003);
    pat <= 4'h3;
    settle();
    outs(4'h0);
    chk("sleep", {31'h0, sleep_mode}, 32'h1);
    bus(`MCS_A_CTRL, 1'b1, 32'h3);
    pat <= 4'h1;
    kick();
    outs(4'h9);
    pat <= 4'h0;
    settle();
    chk("error", {31'h0, error_flag}, 32'h1); outs(4'h0);
    pat <= 4'h1;
    settle();
    kick();
    chk("error", {31'h0, error_flag}, 32'h0); outs(4'h9);
    bad <= 1'b1;
    settle();
    chk("error", {31'h0, error_flag}, 32'h1); outs(4'h0);
    bad <= 1'b0;
    kick();
    // interlock on: a dropped path keeps its safety output off until restart
    bus(`MCS_A_CTRL, 1'b1, 32'h13);
    field_hit <= 4'h1;
    settle();
    field_hit <= 4'h0;
    settle();
    outs(4'h8);
    kick();
    outs(4'h9);
    // range mode: a speed outside every range leaves no case
    bus(`MCS_A_CTRL, 1'b1, 32'h7);
    settle();
    outs(4'h9);
    spd <= 16'd200;
    spd_b <= 16'd200;
    settle();
    outs(4'h0);
    chk("error", {31'h0, error_flag}, 32'h1);
    spd <= 16'd50;
    spd_b <= 16'd50;
    kick();
    bus(`MCS_A_CTRL, 1'b1, 32'hB);
    settle();
    outs(4'h9);
    spd <= 16'd200;
    spd_b <= 16'd200;
    settle();
    outs(4'h0);
    // encoder mismatch: tolerated for the limit, then safety off
    spd <= 16'd50;
    spd_b <= 16'd90;
    repeat (12) @(posedge clk);
    outs(4'h9);
    repeat (12) @(posedge clk);
    outs(4'h0);
    conclude();
  end
endmodule
